// ### rtl/cycle_timer.sv
// Down-counter that times one phase of a flash operation.
// Assumes load is a single-cycle pulse on pclk.
`timescale 1ns/1ps
module cycle_timer #(
    parameter int W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Loads the phase length and counts it down to zero, where it holds.
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = count;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Registers the count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // The phase ends in the last counted cycle.
    assign done = (cnt_q == W'(1));
endmodule // cycle_timer

// ### rtl/flash_access.sv
// Self-programming access to program flash and data EEPROM behind an APB register file.
// Assumes the flash array answers a read within the fetch time on the same pclk.
//
// Behaviour
// - A program read uses two instruction cycles, then the word sits in the data pair.
// - The data pair keeps its word until a new read or a firmware write.
// - Operations go to program flash only while the space select bit is set.
// - A program write stalls the processor; the clock and peripherals keep running.
// - For a program write, execution stops after the second setup cycle and resumes when the write ends.
// - A clear write-protect configuration bit blocks every program flash write.
// - The write trigger needs the enable latch set by an earlier access.
// - Clearing the enable latch during a write does not abort it.
// - Each write needs 55h then AAh to the unlock register, then the trigger.
// - The trigger is followed by two instruction cycles of write setup.
// - A write stores the 14-bit word of the data pair at the addressed location.
// - A finished write clears the trigger and sets the sticky done flag.
// - No automatic verify; firmware reads back to check.
// - Reset clears the enable latch; a running power-up timer blocks writes.
// - A clear space select bit directs operations to the data EEPROM.
// - The unlock register stores nothing; it only receives the keys.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module flash_access
    import flash_access_pkg::*;
#(
    parameter int WRITE_TIME_NS = 4000000,
    parameter int WRITE_CLKS = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic program_write_protect,
    input wire logic powerup_timer_running,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [WORD_W-1:0] flash_wdata,
    input wire logic [WORD_W-1:0] flash_rdata,
    output logic flash_prog_space,
    output logic flash_rd,
    output logic flash_wr,
    output logic cpu_stall
);
    // Decodes whether an offset is a mapped register.
    function automatic logic is_mapped(input logic [7:0] a);
        return a == OFF_ADDR_LOW || a == OFF_ADDR_HIGH || a == OFF_DATA_LOW ||
               a == OFF_DATA_HIGH || a == OFF_ACCESS_CTRL || a == OFF_UNLOCK ||
               a == OFF_STATUS;
    endfunction

    // Tells whether the processor is held in a given state.
    function automatic logic holds_cpu(input op_state_t s, input logic prog);
        return s == ST_FETCH || (s == ST_WRITE && prog);
    endfunction

    logic [1:0] wp_sync_q, pwrt_sync_q;
    logic [ADDR_LOW_W-1:0] addr_low_q, addr_low_d;
    logic [ADDR_HIGH_W-1:0] addr_high_q, addr_high_d;
    logic [DATA_LOW_W-1:0] data_low_q, data_low_d;
    logic [DATA_HIGH_W-1:0] data_high_q, data_high_d;
    logic space_q, space_d, wel_q, wel_d, rd_q, rd_d, wr_q, wr_d, done_q, done_d;
    logic op_prog_q, op_prog_d;
    op_state_t state_q, state_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic flash_rd_q, flash_rd_d, flash_wr_q, flash_wr_d, stall_q, stall_d;
    logic wr_fire, start_read, start_write, write_ok, tmr_load, tmr_done;
    logic [TIMER_W-1:0] tmr_count;

    unlock_if unl ();

    unlock_tracker u_unlock (
        .pclk(pclk),
        .presetn(presetn),
        .u(unl)
    );

    cycle_timer #(.W(TIMER_W)) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Brings the two asynchronous level inputs onto pclk.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_sync_q <= 2'h0;
            pwrt_sync_q <= 2'h3;
        end else begin
            wp_sync_q <= {wp_sync_q[0], program_write_protect};
            pwrt_sync_q <= {pwrt_sync_q[0], powerup_timer_running};
        end
    end

    // A write takes effect at the edge where pready is sampled high.
    assign wr_fire = psel && penable && pready_q && pwrite;

    // Unlock keys go to the tracker only; no storage stands behind the register.
    assign unl.key_wr = wr_fire && paddr == OFF_UNLOCK;
    assign unl.key = pwdata[7:0];
    assign unl.other_wr = wr_fire && paddr != OFF_UNLOCK && !start_write;
    assign unl.take = start_write;

    // Write is allowed only with keys, an earlier latch, protection open for program space and timer ended.
    assign write_ok = unl.armed && wel_q &&
                      !(space_q && !wp_sync_q[1]) &&
                      !pwrt_sync_q[1];
    assign start_write = wr_fire && paddr == OFF_ACCESS_CTRL && pwdata[BIT_WR_TRIG] &&
                         state_q == ST_IDLE && write_ok;
    assign start_read = wr_fire && paddr == OFF_ACCESS_CTRL && pwdata[BIT_RD_TRIG] &&
                        !pwdata[BIT_WR_TRIG] && state_q == ST_IDLE;

    // Register file next values and the operation sequencer.
    always_comb begin
        addr_low_d = addr_low_q;
        addr_high_d = addr_high_q;
        data_low_d = data_low_q;
        data_high_d = data_high_q;
        space_d = space_q;
        wel_d = wel_q;
        rd_d = rd_q;
        wr_d = wr_q;
        done_d = done_q;
        op_prog_d = op_prog_q;
        state_d = state_q;
        flash_rd_d = 1'b0;
        flash_wr_d = flash_wr_q;
        tmr_load = 1'b0;
        tmr_count = '0;
        if (wr_fire) begin
            unique case (paddr)
                OFF_ADDR_LOW: addr_low_d = pwdata[ADDR_LOW_W-1:0];
                OFF_ADDR_HIGH: addr_high_d = pwdata[ADDR_HIGH_W-1:0];
                OFF_DATA_LOW: data_low_d = pwdata[DATA_LOW_W-1:0];
                OFF_DATA_HIGH: data_high_d = pwdata[DATA_HIGH_W-1:0];
                OFF_ACCESS_CTRL: begin
                    space_d = pwdata[BIT_SPACE];
                    wel_d = pwdata[BIT_WEL];
                end
                OFF_STATUS: begin
                    if (pwdata[BIT_DONE]) begin
                        done_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        unique case (state_q)
            ST_IDLE: begin
                if (start_write) begin
                    wr_d = 1'b1;
                    op_prog_d = space_q;
                    state_d = ST_SETUP;
                    tmr_load = 1'b1;
                    tmr_count = TIMER_W'(SETUP_CLKS);
                end else if (start_read) begin
                    rd_d = 1'b1;
                    op_prog_d = space_q;
                    state_d = ST_FETCH;
                    flash_rd_d = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = space_q ? TIMER_W'(FETCH_CLKS) : TIMER_W'(EE_READ_CLKS);
                end
            end
            ST_FETCH: begin
                if (tmr_done) begin
                    data_low_d = flash_rdata[DATA_LOW_W-1:0];
                    if (op_prog_q) begin
                        data_high_d = flash_rdata[WORD_W-1:DATA_LOW_W];
                    end
                    rd_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            ST_SETUP: begin
                if (tmr_done) begin
                    flash_wr_d = 1'b1;
                    state_d = ST_WRITE;
                    tmr_load = 1'b1;
                    tmr_count = TIMER_W'(WRITE_CLKS);
                end
            end
            ST_WRITE: begin
                if (tmr_done) begin
                    flash_wr_d = 1'b0;
                    wr_d = 1'b0;
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
        endcase
        // A stored word is never compared with the array; software reads back.
    end

    // Stalls the processor and the bus while fetching or programming flash.
    assign stall_d = holds_cpu(state_d, op_prog_d);

    // APB answer: one wait cycle, then ready unless the processor is held.
    always_comb begin
        pready_d = psel && penable && !pready_q && !holds_cpu(state_q, op_prog_q);
        pslverr_d = pready_d && !is_mapped(paddr);
        prdata_d = prdata_q;
        if (pready_d) begin
            unique case (paddr)
                OFF_ADDR_LOW: prdata_d = 32'(addr_low_q);
                OFF_ADDR_HIGH: prdata_d = 32'(addr_high_q);
                OFF_DATA_LOW: prdata_d = 32'(data_low_q);
                OFF_DATA_HIGH: prdata_d = 32'(data_high_q);
                OFF_ACCESS_CTRL: prdata_d = 32'({space_q, 4'h0, wel_q, wr_q, rd_q});
                OFF_STATUS: prdata_d = 32'(done_q);
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Registers all state; reset clears the enable latch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_low_q <= '0;
            addr_high_q <= '0;
            data_low_q <= '0;
            data_high_q <= '0;
            space_q <= CTRL_RESET;
            wel_q <= CTRL_RESET;
            rd_q <= CTRL_RESET;
            wr_q <= CTRL_RESET;
            done_q <= CTRL_RESET;
            op_prog_q <= CTRL_RESET;
            state_q <= ST_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            flash_rd_q <= 1'b0;
            flash_wr_q <= 1'b0;
            stall_q <= 1'b0;
        end else begin
            addr_low_q <= addr_low_d;
            addr_high_q <= addr_high_d;
            data_low_q <= data_low_d;
            data_high_q <= data_high_d;
            space_q <= space_d;
            wel_q <= wel_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            done_q <= done_d;
            op_prog_q <= op_prog_d;
            state_q <= state_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            flash_rd_q <= flash_rd_d;
            flash_wr_q <= flash_wr_d;
            stall_q <= stall_d;
        end
    end

    // Outputs come straight from flip-flops.
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign flash_addr = {addr_high_q, addr_low_q};
    assign flash_wdata = {data_high_q, data_low_q};
    assign flash_prog_space = op_prog_q;
    assign flash_rd = flash_rd_q;
    assign flash_wr = flash_wr_q;
    assign cpu_stall = stall_q;

    // Checks on the guarded behaviour; the unlock, protect and power-up checks look at the rise of the registered busy bit.
    chk_unlock_needed: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(wr_q) |-> $past(unl.armed) && $past(wel_q))
        else $error("write started without unlock and earlier latch");
    chk_same_access_latch: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_fire && paddr == OFF_ACCESS_CTRL && pwdata[BIT_WR_TRIG] && !wel_q)
        |=> state_q == ST_IDLE)
        else $error("trigger with latch set in same access started a write");
    chk_protect_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(wr_q) && op_prog_q) |-> $past(wp_sync_q[1]))
        else $error("program write started while protected");
    chk_powerup_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(wr_q) |-> !$past(pwrt_sync_q[1]))
        else $error("write started while power-up timer runs");
    chk_fetch_two: assert property (@(posedge pclk) disable iff (!presetn)
        (start_read && space_q) |=> state_q == ST_FETCH [*2] ##1 state_q == ST_IDLE)
        else $error("program fetch did not take two cycles");
    chk_setup_two: assert property (@(posedge pclk) disable iff (!presetn)
        start_write |=> state_q == ST_SETUP [*2] ##1 (state_q == ST_WRITE && flash_wr))
        else $error("write setup did not take two cycles");
    chk_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q != ST_FETCH && !(wr_fire && paddr == OFF_DATA_LOW)) |=> $stable(data_low_q))
        else $error("data low changed without read or firmware write");
    chk_write_stalls: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_WRITE && op_prog_q) |-> cpu_stall && !pready)
        else $error("processor not held during program write");
    chk_latch_no_abort: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_WRITE && !tmr_done) |=> state_q == ST_WRITE && wr_q)
        else $error("write ended before its time");
    chk_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_WRITE && tmr_done) |=> done_q && !wr_q && !flash_wr)
        else $error("write end did not set done and clear trigger");

    cov_prog_read: cover property (@(posedge pclk) disable iff (!presetn)
        start_read && space_q);
    cov_prog_write: cover property (@(posedge pclk) disable iff (!presetn)
        start_write && space_q);
    cov_refused_trigger: cover property (@(posedge pclk) disable iff (!presetn)
        wr_fire && paddr == OFF_ACCESS_CTRL && pwdata[BIT_WR_TRIG] && !write_ok);
endmodule // flash_access

// ### rtl/flash_access_pkg.sv
// Constants, register map and state type of the self-programming flash access block.
// Assumes a 10 MHz pclk and a 32-bit APB register bus.
package flash_access_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_ADDR_LOW = 8'h00;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFF_DATA_LOW = 8'h08;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h0C;
    localparam logic [7:0] OFF_ACCESS_CTRL = 8'h10;
    localparam logic [7:0] OFF_UNLOCK = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // Field positions in the access control register.
    localparam int BIT_RD_TRIG = 0;
    localparam int BIT_WR_TRIG = 1;
    localparam int BIT_WEL = 2;
    localparam int BIT_SPACE = 7;
    // Field position of the write done flag in the status register.
    localparam int BIT_DONE = 0;

    // Field widths and reset values.
    localparam int ADDR_LOW_W = 8;
    localparam int ADDR_HIGH_W = 5;
    localparam int DATA_LOW_W = 8;
    localparam int DATA_HIGH_W = 6;
    localparam int WORD_W = DATA_HIGH_W + DATA_LOW_W;
    localparam int ADDR_W = ADDR_HIGH_W + ADDR_LOW_W;
    localparam logic CTRL_RESET = 1'b0;

    // Unlock keys.
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

    // Timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int INSTR_CYCLE_NS = 100;
    localparam int FETCH_INSTR = 2;
    localparam int SETUP_INSTR = 2;
    localparam int EE_READ_INSTR = 1;
    localparam int FETCH_CLKS = (FETCH_INSTR * INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CLKS = (SETUP_INSTR * INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EE_READ_CLKS =
        (EE_READ_INSTR * INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 24;

    // Sequencer states.
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SETUP, ST_WRITE} op_state_t;

endpackage

// ### rtl/unlock_if.sv
// Interface between the control logic and the unlock sequence tracker.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface unlock_if;
    logic key_wr;
    logic [7:0] key;
    logic other_wr;
    logic take;
    logic armed;

    modport tracker (input key_wr, input key, input other_wr, input take, output armed);
    modport ctl (output key_wr, output key, output other_wr, output take, input armed);
endinterface

// ### rtl/unlock_tracker.sv
// Tracks the two-byte unlock sequence written to the unlock register.
// Assumes one strobe per completed bus write, all on pclk.
`timescale 1ns/1ps
module unlock_tracker
    import flash_access_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    unlock_if.tracker u
);
    logic [1:0] stage_q;
    logic [1:0] stage_d;

    // Any other write, a wrong key or a consumed trigger restarts the sequence.
    always_comb begin
        stage_d = stage_q;
        if (u.take || u.other_wr) begin
            stage_d = 2'h0;
        end else if (u.key_wr) begin
            if (u.key == UNLOCK_KEY1) begin
                stage_d = 2'h1;
            end else if (u.key == UNLOCK_KEY2 && stage_q == 2'h1) begin
                stage_d = 2'h2;
            end else begin
                stage_d = 2'h0;
            end
        end
    end

    // Registers the sequence stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q <= 2'h0;
        end else begin
            stage_q <= stage_d;
        end
    end

    assign u.armed = (stage_q == 2'h2);
endmodule // unlock_tracker

// ### sim/tb_flash_access.sv
// Self-checking bench for the flash access block: APB master tasks and a flash array model.
// Assumes the block is the only APB slave and drives the array ports on pclk.
`timescale 1ns/1ps
module tb_flash_access;
    import flash_access_pkg::*;
    localparam int WCLK = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q, err_q;
    logic program_write_protect, powerup_timer_running;
    logic [ADDR_W-1:0] flash_addr, cap_addr;
    logic [WORD_W-1:0] flash_wdata, flash_rdata, cap_data;
    logic flash_prog_space, flash_rd, flash_wr, cpu_stall, cap_space, rd_space;
    logic wr_prev = 1'b0;
    logic [WORD_W-1:0] mem [0:8191];
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int wr_rises = 0;
    int wr_len = 0;
    int stall_bad = 0;

    flash_access #(.WRITE_TIME_NS(1000)) i_flash_access (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .program_write_protect,
        .powerup_timer_running, .flash_addr, .flash_wdata, .flash_rdata, .flash_prog_space,
        .flash_rd, .flash_wr, .cpu_stall);

    // The array answers with the word at the current address.
    assign flash_rdata = mem[flash_addr];

    // Clock of 100 ns period.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Array model: stores program words and watches the write strobe and the stall.
    always @(posedge pclk) begin
        wr_prev <= flash_wr;
        if (flash_rd) rd_space <= flash_prog_space;
        if (flash_wr) wr_len <= wr_len + 1;
        if (flash_wr && !wr_prev) begin
            wr_rises <= wr_rises + 1;
            wr_len <= 1;
            cap_addr <= flash_addr;
            cap_data <= flash_wdata;
            cap_space <= flash_prog_space;
            if (flash_prog_space) mem[flash_addr] <= flash_wdata;
        end
        if (flash_wr && cpu_stall !== flash_prog_space) stall_bad <= stall_bad + 1;
    end

    // Cuts a hung run short.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    // One APB transfer; waits for pready and takes the answer at that edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        rd_q = prdata;
        err_q = {31'h0, pslverr};
        chk("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
        xfer(1'b0, a, 32'h0);
        chk(name, e, rd_q);
    endtask

    // Write attempt: latch, two keys, trigger, then latch clear, held off by the stall until a program write ends.
    task automatic attempt(input logic [7:0] k1, k2, sp, input logic gap, pre, input int e);
        int r;
        r = wr_rises;
        wr(OFF_ACCESS_CTRL, {24'h0, sp | (pre ? 8'h04 : 8'h00)});
        wr(OFF_UNLOCK, {24'h0, k1});
        if (gap) wr(OFF_STATUS, 32'h0);
        wr(OFF_UNLOCK, {24'h0, k2});
        wr(OFF_ACCESS_CTRL, {24'h0, sp | 8'h06});
        wr(OFF_ACCESS_CTRL, {24'h0, sp});
        chk("write count", 32'(e), 32'(wr_rises - r));
    endtask

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = 14'(i * 5) ^ 14'h2A5A;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        program_write_protect = 1'b1;
        powerup_timer_running = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_ACCESS_CTRL, 32'h0, "ctrl reset");
        rd(OFF_STATUS, 32'h0, "status reset");
        xfer(1'b0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, err_q);
        chk("unmapped data", 32'h0, rd_q);
        wr(OFF_UNLOCK, 32'h55);
        rd(OFF_UNLOCK, 32'h0, "unlock read");
        wr(OFF_ADDR_HIGH, 32'hFF);
        rd(OFF_ADDR_HIGH, 32'h1F, "addr high");
        // Program fetch from 153C, then hold and overwrite of the data pair.
        wr(OFF_ADDR_HIGH, 32'h15);
        wr(OFF_ADDR_LOW, 32'h3C);
        wr(OFF_ACCESS_CTRL, 32'h80);
        wr(OFF_ACCESS_CTRL, 32'h81);
        rd(OFF_ACCESS_CTRL, 32'h80, "ctrl after read");
        chk("fetch space", 32'h1, {31'h0, rd_space});
        rd(OFF_DATA_LOW, {24'h0, mem[13'h153C][7:0]}, "data low");
        rd(OFF_DATA_HIGH, {26'h0, mem[13'h153C][13:8]}, "data high");
        wr(OFF_ADDR_LOW, 32'h3D);
        rd(OFF_DATA_LOW, {24'h0, mem[13'h153C][7:0]}, "data held");
        wr(OFF_DATA_LOW, 32'hC3);
        rd(OFF_DATA_LOW, 32'hC3, "data overwrite");
        wr(OFF_DATA_HIGH, 32'h2E);
        // Program write of 2EC3 at 153D.
        attempt(8'h55, 8'hAA, 8'h80, 1'b0, 1'b1, 1);
        chk("write addr", 32'h153D, {19'h0, cap_addr});
        chk("write data", 32'h2EC3, {18'h0, cap_data});
        chk("write length", 32'(WCLK), 32'(wr_len));
        chk("stall", 32'h0, 32'(stall_bad));
        rd(OFF_STATUS, 32'h1, "done flag");
        rd(OFF_ACCESS_CTRL, 32'h80, "trigger cleared");
        wr(OFF_STATUS, 32'h1);
        rd(OFF_STATUS, 32'h0, "done cleared");
        wr(OFF_ACCESS_CTRL, 32'h81);
        rd(OFF_DATA_LOW, 32'hC3, "readback low");
        rd(OFF_DATA_HIGH, 32'h2E, "readback high");
        // Refused attempts.
        attempt(8'hAA, 8'h55, 8'h80, 1'b0, 1'b1, 0);
        attempt(8'h55, 8'hAA, 8'h80, 1'b0, 1'b0, 0);
        attempt(8'h55, 8'hAA, 8'h80, 1'b1, 1'b1, 0);
        attempt(8'h55, 8'hAB, 8'h80, 1'b0, 1'b1, 0);
        powerup_timer_running <= 1'b1;
        attempt(8'h55, 8'hAA, 8'h80, 1'b0, 1'b1, 0);
        powerup_timer_running <= 1'b0;
        program_write_protect <= 1'b0;
        attempt(8'h55, 8'hAA, 8'h80, 1'b0, 1'b1, 0);
        rd(OFF_STATUS, 32'h0, "no done");
        // Data EEPROM write and read while program writes are protected.
        attempt(8'h55, 8'hAA, 8'h00, 1'b0, 1'b1, 1);
        chk("eeprom space", 32'h0, {31'h0, cap_space});
        // A data EEPROM write leaves the bus free, so wait for its end before the read.
        repeat (WCLK) @(posedge pclk);
        chk("eeprom stall", 32'h0, 32'(stall_bad));
        rd(OFF_STATUS, 32'h1, "eeprom done");
        wr(OFF_ACCESS_CTRL, 32'h01);
        rd(OFF_DATA_HIGH, 32'h2E, "eeprom high kept");
        chk("eeprom read space", 32'h0, {31'h0, rd_space});
        print_verdict();
    end
endmodule // tb_flash_access
